// [verilog/wdt_ctrl.v]
// Watchdog/interval timer registers, keyed access and overflow handling.
`timescale 1ns/100ps
`include "wdt_consts.vh"
module wdt_ctrl (
    // Clock and external reset pin (already synchronous).
    input wire clk_sys_in,
    input wire reset_in,
    // Standby entry, one-cycle pulse from power control.
    input wire standby_enter_in,
    // CPU register bus, one-cycle strobes.
    input wire [27:0] bus_addr_in,
    input wire bus_write_in,
    input wire bus_read_in,
    input wire bus_word_in,
    input wire [15:0] bus_wdata_in,
    output reg [7:0] bus_rdata_out,
    // Events.
    output reg interval_irq_out,
    output reg overflow_out_n_out,
    output reg chip_reset_req_out,
    output reg chip_reset_manual_out
);
    // ==================================================
    // Register state
    reg interval_overflow_flag;
    reg timer_mode_select;
    reg count_enable_bit;
    reg [2:0] clock_divider_select;
    reg [7:0] watchdog_count;
    reg watchdog_overflow_flag;
    reg chip_reset_enable;
    reg reset_type_select;
    reg ovf_seen;
    reg watchdog_overflow_flag_seen;
    wire tick;
    wire ovf_pulse;
    wire rst_pulse;

    // Word write only; a byte write to these addresses is ignored.
    function wr_hit;
        input [27:0] a;
        begin
            wr_hit = bus_write_in && bus_word_in && (bus_addr_in == a);
        end
    endfunction

    wire [7:0] hi = bus_wdata_in[15:8];
    wire [7:0] lo = bus_wdata_in[7:0];
    wire wr_ctrl = wr_hit(`WDT_ADDR_WR_CTRL) && (hi == `WDT_KEY_B);
    wire wr_count = wr_hit(`WDT_ADDR_WR_CTRL) && (hi == `WDT_KEY_A);
    wire wr_rst_clr = wr_hit(`WDT_ADDR_WR_RST) && (hi == `WDT_KEY_B) && (lo == 8'h00);
    wire wr_rst_cfg = wr_hit(`WDT_ADDR_WR_RST) && (hi == `WDT_KEY_A);
    // A counter write that meets a tick wins, so no overflow is flagged then.
    wire wrap = tick && count_enable_bit && (watchdog_count == 8'hFF) && !wr_count;
    wire wd_wrap = wrap && timer_mode_select;
    wire it_wrap = wrap && !timer_mode_select;
    wire [7:0] ctrl_view = {interval_overflow_flag, timer_mode_select, count_enable_bit,
                            2'h3, clock_divider_select};
    wire [7:0] rst_view = {watchdog_overflow_flag, chip_reset_enable, reset_type_select,
                           5'h1F};

    // ==================================================
    // Sub-blocks
    wdt_prescaler u_pre (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .select_in(clock_divider_select),
        .run_in(count_enable_bit),
        .tick_out(tick)
    );

    wdt_pulse u_ovf (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .start_in(wd_wrap),
        .length_in(`WDT_OVF_PULSE_CYC),
        .active_out(ovf_pulse)
    );

    wdt_pulse u_rst (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .start_in(wd_wrap && chip_reset_enable),
        .length_in(`WDT_RST_PULSE_CYC),
        .active_out(rst_pulse)
    );

    // ==================================================
    // Timer control/status and counter. A watchdog wrap clears both
    // whether or not the chip is reset, so the wrap also acts as a clear.
    always @(posedge clk_sys_in) begin
        if (reset_in || wd_wrap) begin
            interval_overflow_flag <= 1'b0;
            timer_mode_select <= 1'b0;
            count_enable_bit <= 1'b0;
            clock_divider_select <= 3'h0;
            watchdog_count <= 8'h00;
            ovf_seen <= 1'b0;
        end else if (standby_enter_in) begin
            interval_overflow_flag <= 1'b0;
            timer_mode_select <= 1'b0;
            count_enable_bit <= 1'b0;
            ovf_seen <= 1'b0;
        end else begin
            // Remember a read that saw the flag set.
            if (bus_read_in && bus_addr_in == `WDT_ADDR_RD_CTRL && interval_overflow_flag) begin
                ovf_seen <= 1'b1;
            end
            if (wr_ctrl) begin
                timer_mode_select <= lo[`WDT_BIT_MODE];
                count_enable_bit <= lo[`WDT_BIT_EN];
                clock_divider_select <= lo[2:0];
            end
            // Set wins over a coincident clear.
            if (it_wrap) begin
                interval_overflow_flag <= 1'b1;
            end else if (wr_ctrl && !lo[`WDT_BIT_OVF] && ovf_seen) begin
                interval_overflow_flag <= 1'b0;
                ovf_seen <= 1'b0;
            end
            // Counter: disabled holds zero, a write beats a tick.
            if (wr_ctrl && !lo[`WDT_BIT_EN]) begin
                watchdog_count <= 8'h00;
            end else if (!count_enable_bit) begin
                watchdog_count <= 8'h00;
            end else if (wr_count) begin
                watchdog_count <= lo;
            end else if (tick) begin
                watchdog_count <= watchdog_count + 8'h01;
            end
        end
    end

    // ==================================================
    // Reset control/status. The watchdog's own chip reset does not touch it.
    always @(posedge clk_sys_in) begin
        if (reset_in || standby_enter_in) begin
            watchdog_overflow_flag <= 1'b0;
            chip_reset_enable <= 1'b0;
            reset_type_select <= 1'b0;
            watchdog_overflow_flag_seen <= 1'b0;
        end else begin
            if (bus_read_in && bus_addr_in == `WDT_ADDR_RD_RST && watchdog_overflow_flag) begin
                watchdog_overflow_flag_seen <= 1'b1;
            end
            if (wd_wrap) begin
                watchdog_overflow_flag <= 1'b1;
            end else if (wr_rst_clr && watchdog_overflow_flag_seen) begin
                watchdog_overflow_flag <= 1'b0;
                watchdog_overflow_flag_seen <= 1'b0;
            end
            if (wr_rst_cfg) begin
                chip_reset_enable <= lo[`WDT_BIT_CHIP_RESET_ENABLE];
                reset_type_select <= lo[`WDT_BIT_RESET_TYPE_SELECT];
            end
        end
    end

    // ==================================================
    // Byte read mux, registered. Unmapped addresses read zero.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            bus_rdata_out <= 8'h00;
        end else if (bus_read_in) begin
            case (bus_addr_in)
                `WDT_ADDR_RD_CTRL: bus_rdata_out <= ctrl_view;
                `WDT_ADDR_RD_COUNT: bus_rdata_out <= watchdog_count;
                `WDT_ADDR_RD_RST: bus_rdata_out <= rst_view;
                default: bus_rdata_out <= 8'h00;
            endcase
        end
    end

    // ==================================================
    // Event outputs, each from a flip-flop. The interrupt is a level
    // that follows the flag, so it lags the flag by one cycle.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            interval_irq_out <= 1'b0;
            overflow_out_n_out <= 1'b1;
            chip_reset_req_out <= 1'b0;
            chip_reset_manual_out <= 1'b0;
        end else begin
            interval_irq_out <= interval_overflow_flag;
            overflow_out_n_out <= !ovf_pulse;
            chip_reset_req_out <= rst_pulse;
            chip_reset_manual_out <= rst_pulse && reset_type_select;
        end
    end
endmodule

// [verilog/wdt_consts.vh]
// Constants of the watchdog/interval timer control block.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
// ==================================================
// Addresses
`define WDT_ADDR_WR_CTRL 28'h5FFFFB8
`define WDT_ADDR_WR_RST 28'h5FFFFBA
`define WDT_ADDR_RD_CTRL 28'h5FFFFB8
`define WDT_ADDR_RD_COUNT 28'h5FFFFB9
`define WDT_ADDR_RD_RST 28'h5FFFFBB
// ==================================================
// Keys
`define WDT_KEY_A 8'h5A
`define WDT_KEY_B 8'hA5
// ==================================================
// Field positions
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_EN 5
`define WDT_BIT_WATCHDOG_OVERFLOW_FLAG 7
`define WDT_BIT_CHIP_RESET_ENABLE 6
`define WDT_BIT_RESET_TYPE_SELECT 5
// ==================================================
// Reset values and fixed ones
`define WDT_CTRL_ONES 8'h18
`define WDT_RST_ONES 8'h1F
// ==================================================
// Timing counts in system clock cycles
`define WDT_OVF_PULSE_CYC 10'h080
`define WDT_RST_PULSE_CYC 10'h200
`endif

// [verilog/wdt_prescaler.v]
// Prescaler, held at zero while stopped, giving one-cycle count ticks at the selected rate.
`timescale 1ns/100ps
`include "wdt_consts.vh"
module wdt_prescaler (
    // Clock and reset.
    input wire clk_sys_in,
    input wire reset_in,
    // Rate select and run control.
    input wire [2:0] select_in,
    input wire run_in,
    // One-cycle tick.
    output reg tick_out
);
    reg [12:0] div;
    reg [12:0] mask;

    // Mask of the divider bits that must be all ones for a tick.
    always @* begin
        case (select_in)
            3'h0: mask = 13'h0001;
            3'h1: mask = 13'h003F;
            3'h2: mask = 13'h007F;
            3'h3: mask = 13'h00FF;
            3'h4: mask = 13'h01FF;
            3'h5: mask = 13'h03FF;
            3'h6: mask = 13'h0FFF;
            default: mask = 13'h1FFF;
        endcase
    end

    // The divider restarts while stopped so the first interval is full length.
    always @(posedge clk_sys_in) begin
        if (reset_in || !run_in) begin
            div <= 13'h0000;
            tick_out <= 1'b0;
        end else begin
            div <= div + 13'h0001;
            tick_out <= ((div & mask) == mask);
        end
    end
endmodule

// [verilog/wdt_pulse.v]
// Fixed-length pulse stretcher for the overflow pin and reset request.
`timescale 1ns/100ps
`include "wdt_consts.vh"
module wdt_pulse (
    // Clock and reset.
    input wire clk_sys_in,
    input wire reset_in,
    // Trigger and length.
    input wire start_in,
    input wire [9:0] length_in,
    // Pulse.
    output reg active_out
);
    reg [9:0] left;

    // A retrigger while active restarts the count.
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            left <= 10'h000;
            active_out <= 1'b0;
        end else if (start_in) begin
            left <= length_in - 10'h001;
            active_out <= 1'b1;
        end else if (left != 10'h000) begin
            left <= left - 10'h001;
        end else begin
            active_out <= 1'b0;
        end
    end
endmodule

// [verification/wdt_ctrl_checker.sv]
// Concurrent checks on the ports of the watchdog timer control block.
`timescale 1ns/100ps
`include "wdt_consts.vh"
module wdt_ctrl_checker (
    // Clock and reset.
    input wire clk_sys_in,
    input wire reset_in,
    // Register bus.
    input wire bus_read_in,
    input wire [27:0] bus_addr_in,
    input wire [7:0] bus_rdata_out,
    // Events.
    input wire interval_irq_out,
    input wire overflow_out_n_out,
    input wire chip_reset_req_out,
    input wire chip_reset_manual_out
);
    reg [9:0] lo_cnt;
    reg [9:0] hi_cnt;
    // ==========================================================
    // Pulse length counters, since a repetition cannot reach 512 cycles.
    always @(posedge clk_sys_in) begin
        lo_cnt <= (reset_in || overflow_out_n_out) ? 10'h000 : lo_cnt + 10'h001;
        hi_cnt <= (reset_in || !chip_reset_req_out) ? 10'h000 : hi_cnt + 10'h001;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // A read strobe aimed at one byte address.
    sequence s_rd(a);
        bus_read_in && bus_addr_in == a;
    endsequence
    // ==========================================================
    a_pin_len: assert property ($rose(overflow_out_n_out) |-> lo_cnt == 10'h080)
        else $error("overflow pin pulse length wrong");
    a_pin_bound: assert property (lo_cnt <= 10'h080)
        else $error("overflow pin pulse too long");
    a_req_len: assert property ($fell(chip_reset_req_out) |-> hi_cnt == 10'h200)
        else $error("chip reset request length wrong");
    a_req_with_pin: assert property (
        $rose(chip_reset_req_out) |-> !overflow_out_n_out)
        else $error("chip reset request without overflow pin");
    a_manual_req: assert property (chip_reset_manual_out |-> chip_reset_req_out)
        else $error("manual reset type without request");
    a_irq_quiet: assert property (!overflow_out_n_out |-> !interval_irq_out)
        else $error("interval interrupt during watchdog overflow");
    a_ctrl_ones: assert property (
        s_rd(`WDT_ADDR_RD_CTRL) |=> bus_rdata_out[4:3] == 2'b11)
        else $error("control reserved bits not one");
    a_rst_ones: assert property (
        s_rd(`WDT_ADDR_RD_RST) |=> bus_rdata_out[4:0] == 5'h1F)
        else $error("reset register reserved bits not one");
    a_unmapped: assert property (s_rd(`WDT_ADDR_WR_RST) |=> bus_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind wdt_ctrl wdt_ctrl_checker u_chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .bus_read_in(bus_read_in), .bus_addr_in(bus_addr_in), .bus_rdata_out(bus_rdata_out),
    .interval_irq_out(interval_irq_out), .overflow_out_n_out(overflow_out_n_out),
    .chip_reset_req_out(chip_reset_req_out), .chip_reset_manual_out(chip_reset_manual_out));

// [verification/tb_top.sv]
// Self-checking testbench of the watchdog timer control block.
`timescale 1ns/100ps
`include "wdt_consts.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic clk_sys_in, reset_in, standby_enter_in, bus_write_in, bus_read_in, bus_word_in;
    logic [27:0] bus_addr_in;
    logic [15:0] bus_wdata_in;
    wire [7:0] bus_rdata_out;
    wire interval_irq_out, overflow_out_n_out, chip_reset_req_out, chip_reset_manual_out;
    int error_cnt = 0;
    int num_checks = 0;
    int i, n;
    logic [31:0] v;
    logic [7:0] d;
    wdt_ctrl u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .standby_enter_in(standby_enter_in), .bus_addr_in(bus_addr_in),
        .bus_write_in(bus_write_in), .bus_read_in(bus_read_in), .bus_word_in(bus_word_in),
        .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
        .interval_irq_out(interval_irq_out), .overflow_out_n_out(overflow_out_n_out),
        .chip_reset_req_out(chip_reset_req_out), .chip_reset_manual_out(chip_reset_manual_out));
    // ==========================================================
    // Every task starts and ends just after a rising edge, so inputs never race it.
    task automatic step(input int c);
        repeat (c) @(posedge clk_sys_in);
        #10;
    endtask
    task automatic wr(input [27:0] a, input w, input [15:0] x);
        bus_addr_in = a;
        bus_word_in = w;
        bus_wdata_in = x;
        bus_write_in = 1'b1;
        step(1);
        bus_write_in = 1'b0;
        // An idle cycle, so the next call never raises the strobe in this time step.
        step(1);
    endtask
    task automatic rd(input [27:0] a, output [7:0] q);
        bus_addr_in = a;
        bus_read_in = 1'b1;
        step(1);
        q = bus_rdata_out;
        bus_read_in = 1'b0;
        step(1);
    endtask
    task automatic rdc(input [27:0] a, input [7:0] e);
        logic [7:0] q;
        rd(a, q);
        `CHK("rdata", e, q)
    endtask
    // Divisor of each rate code; two spacings so the table stays a formula.
    function automatic int dv(input int c);
        dv = (c == 0) ? 2 : (c < 6) ? (32 << c) : (64 << c);
    endfunction
    task automatic results;
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // Cut a hang short well after the slowest rate has had its turn.
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        error_cnt++;
        results;
    end
    initial begin
        {reset_in, standby_enter_in, bus_write_in, bus_read_in, bus_word_in} = 5'h10;
        bus_addr_in = 28'h0000000;
        bus_wdata_in = 16'h0000;
        v = $urandom(4);
        step(12);
        reset_in = 1'b0;
        rdc(`WDT_ADDR_RD_CTRL, 8'h18);
        rdc(`WDT_ADDR_RD_COUNT, 8'h00);
        rdc(`WDT_ADDR_RD_RST, 8'h1F);
        rdc(`WDT_ADDR_WR_RST, 8'h00);
        // Byte writes and wrong keys must leave everything alone.
        wr(`WDT_ADDR_WR_CTRL, 1'b0, {`WDT_KEY_B, 8'h38});
        wr(`WDT_ADDR_WR_CTRL, 1'b1, 16'h3338);
        wr(`WDT_ADDR_WR_RST, 1'b1, 16'h337F);
        wr(`WDT_ADDR_WR_RST, 1'b0, {`WDT_KEY_A, 8'h7F});
        rdc(`WDT_ADDR_RD_CTRL, 8'h18);
        rdc(`WDT_ADDR_RD_RST, 8'h1F);
        // Reserved control bits are always written as ones.
        for (i = 0; i < 8; i++) begin
            v = $urandom;
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 1'b0, v[6], 3'b011, i[2:0]});
            rdc(`WDT_ADDR_RD_CTRL, {1'b0, v[6], 3'b011, i[2:0]});
        end
        // Slowest rate, so a tick between write and read is unlikely.
        wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 8'h3F});
        wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_A, v[7:0]});
        rd(`WDT_ADDR_RD_COUNT, d);
        if (d === v[7:0] + 8'h01)
            d = v[7:0];
        `CHK("count", v[7:0], d)
        wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 8'h1F});
        rdc(`WDT_ADDR_RD_COUNT, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 5'b00111, i[2:0]});
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_A, 8'hFE});
            n = 0;
            while (interval_irq_out !== 1'b1 && n < 20000) begin
                step(1);
                n++;
            end
            `CHK("rate", 1'b1, n >= dv(i) && n <= 2 * dv(i) + 6)
            `CHK("pin", 1'b1, overflow_out_n_out)
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 5'b00111, i[2:0]});
            rdc(`WDT_ADDR_RD_CTRL, {5'b10111, i[2:0]});
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 5'b00111, i[2:0]});
            step(2);
            `CHK("irq", 1'b0, interval_irq_out)
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 5'b00011, i[2:0]});
        end
        // Watchdog overflow with chip reset enabled, then disabled.
        for (i = 0; i < 2; i++) begin
            v = $urandom;
            wr(`WDT_ADDR_WR_RST, 1'b1, {`WDT_KEY_A, 1'b0, ~i[0], v[5], 5'h1F});
            rdc(`WDT_ADDR_RD_RST, {1'b0, ~i[0], v[5], 5'h1F});
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 8'h78});
            wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_A, 8'hFE});
            n = 0;
            while (overflow_out_n_out !== 1'b0 && n < 50) begin
                step(1);
                n++;
            end
            step(1);
            `CHK("req", ~i[0], chip_reset_req_out)
            `CHK("manual", ~i[0] & v[5], chip_reset_manual_out)
            rdc(`WDT_ADDR_RD_CTRL, 8'h18);
            rdc(`WDT_ADDR_RD_COUNT, 8'h00);
            // A clearing write before any read of the set flag must be refused.
            wr(`WDT_ADDR_WR_RST, 1'b1, {`WDT_KEY_B, 8'h00});
            rdc(`WDT_ADDR_RD_RST, {1'b1, ~i[0], v[5], 5'h1F});
            wr(`WDT_ADDR_WR_RST, 1'b1, {`WDT_KEY_B, 8'h1F});
            rdc(`WDT_ADDR_RD_RST, {1'b1, ~i[0], v[5], 5'h1F});
            wr(`WDT_ADDR_WR_RST, 1'b1, {`WDT_KEY_B, 8'h00});
            rdc(`WDT_ADDR_RD_RST, {1'b0, ~i[0], v[5], 5'h1F});
            step(600);
        end
        // Standby keeps the rate code but clears the rest.
        wr(`WDT_ADDR_WR_CTRL, 1'b1, {`WDT_KEY_B, 8'h5D});
        wr(`WDT_ADDR_WR_RST, 1'b1, {`WDT_KEY_A, 8'h7F});
        standby_enter_in = 1'b1;
        step(1);
        standby_enter_in = 1'b0;
        rdc(`WDT_ADDR_RD_CTRL, 8'h1D);
        rdc(`WDT_ADDR_RD_RST, 8'h1F);
        results;
    end
endmodule
